// ---- logic/prcd_pkg.sv ----
// constants shared by both ends of the power rail command link
// What this block does
// R01 - host keeps rail off while changing settings (not enforced by the host logic, left to software)
// R02 - device answers every read at any time
// R03 - new configuration takes effect on re-enable
// R04 - host waits 100ms after store or restore
// R05 - host spaces reads at least 2ms apart
// R06 - host spaces other commands 5ms apart
// R07 - short linear: 5-bit exponent, 11-bit mantissa
// R08 - unsigned 16-bit mantissa, exponent fixed minus thirteen
// R09 - signed 16-bit mantissa, exponent fixed minus thirteen
// R10 - text format is variable-length ASCII string
// R11 - select 00h, 01h or ffh routes commands
// R12 - select resets to 00h, never write protected
// R13 - run-control decodes off, soft off, on, margins
// R14 - immediate off skips delay and fall time
// R15 - run-control read shows live on/off state
// R16 - unlisted run-control encodings raise command error
// R17 - run-control per controller, protected, resets off
// R18 - config bits 4:2 pick pin or command start
// R19 - config bit 1 ignored, pin active high
// R20 - config bit 0 picks immediate or ramped off
// R21 - power switch configuration resets to 17h
// R22 - bad select value errors, selection kept
package prcd_pkg;
    // command codes, used as register offsets on the link
    localparam logic [7:0] CMD_SELECT    = 8'h00;
    localparam logic [7:0] CMD_RUN       = 8'h01;
    localparam logic [7:0] CMD_PSC       = 8'h02;
    localparam logic [7:0] CMD_STORE_DEF = 8'h11;
    localparam logic [7:0] CMD_REST_DEF  = 8'h12;
    localparam logic [7:0] CMD_STORE_USR = 8'h15;
    localparam logic [7:0] CMD_REST_USR  = 8'h16;
    // controller select values
    localparam logic [7:0] SEL_CTL0 = 8'h00; // [R11]
    localparam logic [7:0] SEL_CTL1 = 8'h01; // [R11]
    localparam logic [7:0] SEL_BOTH = 8'hff; // [R11]
    localparam logic [7:0] SEL_RST  = 8'h00; // [R12]
    // run-control fields
    localparam logic [1:0] RUN_IMM_OFF  = 2'h0; // [R13]
    localparam logic [1:0] RUN_SOFT_OFF = 2'h1; // [R13]
    localparam logic [1:0] RUN_ON       = 2'h2; // [R13]
    localparam logic [1:0] MRG_NOM      = 2'h0; // [R13]
    localparam logic [1:0] MRG_LOW      = 2'h1; // [R13]
    localparam logic [1:0] MRG_HIGH     = 2'h2; // [R13]
    localparam logic [7:0] RUN_RST      = 8'h00; // [R17]
    // power switch configuration fields
    localparam logic [2:0] SRC_PIN  = 3'h5; // [R18]
    localparam logic [2:0] SRC_CMD  = 3'h6; // [R18]
    localparam int         PSC_IMM_BIT = 0; // [R20]
    localparam logic [7:0] PSC_RST  = 8'h17; // [R21]
    // numeric formats carried in data words
    localparam int SLF_EXP_W = 5;  // [R07] upper bits, two's complement exponent
    localparam int SLF_MAN_W = 11; // [R07] lower bits, two's complement mantissa
    localparam int FIX_EXP   = -13; // [R08] [R09] shared by both fixed formats
    localparam int FIX_MAN_W = 16;  // [R08] [R09] unsigned or signed mantissa
    localparam int TEXT_CHAR_W = 8; // [R10] one ASCII character per byte
    // link frame: read flag, 8 code bits, 8 data bits
    localparam logic [4:0] FRM_BITS = 5'd17;
    localparam logic [4:0] FRM_CODE_END = 5'd8;
    // host pacing and clocking
    localparam int CLK_MHZ      = 200;
    localparam int READ_GAP_MS  = 2;   // [R05]
    localparam int CMD_GAP_MS   = 5;   // [R06]
    localparam int NV_GAP_MS    = 100; // [R04]
    localparam int READ_GAP_CYC = READ_GAP_MS * 1000 * CLK_MHZ;
    localparam int CMD_GAP_CYC  = CMD_GAP_MS * 1000 * CLK_MHZ;
    localparam int NV_GAP_CYC   = NV_GAP_MS * 1000 * CLK_MHZ;
    // host avalon register map, byte addresses
    localparam logic [3:0] HREG_CMD    = 4'h0;
    localparam logic [3:0] HREG_STATUS = 4'h4;
    localparam int HCMD_RD_BIT  = 16;
    localparam int HST_BUSY_BIT = 0;
endpackage

// ---- logic/prcd_if.sv ----
// serial link between host controller and power rail command decoder
`timescale 1ns/1ps
`default_nettype none
interface prcd_if;
    logic link_clk;
    logic link_frame;
    logic host_data;
    logic dev_data;
    modport host (output link_clk, output link_frame, output host_data, input dev_data);
    modport dev  (input link_clk, input link_frame, input host_data, output dev_data);
endinterface
`default_nettype wire

// ---- logic/prcd_sync.sv ----
// two-flop synchroniser with rising edge detect
`timescale 1ns/1ps
`default_nettype none
module prcd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] lvl,
    output logic      [W-1:0] rise
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] prev_ff;
    // only sync_ff reads the first stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end
    assign lvl  = sync_ff;
    assign rise = sync_ff & ~prev_ff;
endmodule // prcd_sync
`default_nettype wire

// ---- logic/prcd_device.sv ----
// power rail command decoder: link slave, command registers, rail control
`timescale 1ns/1ps
`default_nettype none
module prcd_device (
    input  wire logic       clk,
    input  wire logic       resetn,
    prcd_if.dev             lnk,
    input  wire logic [1:0] en_pin,
    input  wire logic       write_protect,
    input  wire logic       err_clear,
    output logic      [1:0] rail_on,
    output logic      [3:0] margin_sel,
    output logic      [1:0] soft_off,
    output logic            cmd_error
);
    import prcd_pkg::*;

    logic [2:0] lnk_lvl;
    logic [2:0] lnk_rise;
    logic [1:0] en_lvl;
    logic [4:0] bitcnt_ff;
    logic [7:0] shreg_ff;
    logic [7:0] code_ff;
    logic       rd_ff;
    logic [7:0] tx_ff;
    logic [7:0] sel_ff;
    logic [1:0][7:0] run_ff;
    logic [1:0][7:0] psc_ff;
    logic [1:0][7:0] act_psc_ff;
    logic [1:0] rail_ff;
    logic [1:0] soft_ff;
    logic [3:0] mrg_ff;
    logic       err_ff;
    logic       frame;
    logic       bit_in;
    logic       rise_bit;
    logic [7:0] byte_in;
    logic       wr_now;
    logic [1:0] tgt;
    logic       idx;
    logic [7:0] rd_val;
    logic       run_ok;
    logic       wr_err;
    logic [1:0] run_we;
    logic [1:0] psc_we;

    // link pins come from another party, so all pass two flops
    prcd_sync #(.W(3)) u_lnk_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    ({lnk.link_clk, lnk.link_frame, lnk.host_data}),
        .lvl    (lnk_lvl),
        .rise   (lnk_rise)
    );
    prcd_sync #(.W(2)) u_en_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (en_pin),
        .lvl    (en_lvl),
        .rise   ()
    );

    assign frame    = lnk_lvl[1];
    assign bit_in   = lnk_lvl[0];
    assign rise_bit = lnk_rise[2] & frame;
    assign byte_in  = {shreg_ff[6:0], bit_in};
    assign wr_now   = rise_bit && (bitcnt_ff == FRM_BITS - 5'd1) && !rd_ff;
    assign idx      = (sel_ff == SEL_CTL1);

    // bit counter restarts with every frame, so a cut frame leaves no trace
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bitcnt_ff <= 5'd0;
        end else if (!frame) begin
            bitcnt_ff <= 5'd0;
        end else if (rise_bit && bitcnt_ff != FRM_BITS) begin
            bitcnt_ff <= bitcnt_ff + 5'd1;
        end
    end

    // incoming shift register; read flag and code captured after the code byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shreg_ff <= 8'h00;
            code_ff  <= 8'h00;
            rd_ff    <= 1'b0;
        end else if (rise_bit) begin
            shreg_ff <= byte_in;
            if (bitcnt_ff == FRM_CODE_END) begin
                code_ff <= byte_in;
                rd_ff   <= shreg_ff[7];
            end
        end
    end

    // read mux: every command answers, whatever the rail is doing
    always_comb begin
        rd_val = 8'h00;
        unique case (byte_in)
            CMD_SELECT: rd_val = sel_ff; // [R02]
            CMD_RUN: begin
                // live state, not the stored byte: on, soft off or immediate off
                rd_val[7:6] = rail_ff[idx] ? RUN_ON :
                              (soft_ff[idx] ? RUN_SOFT_OFF : RUN_IMM_OFF); // [R15]
                rd_val[5:4] = run_ff[idx][5:4];
            end
            CMD_PSC: rd_val = psc_ff[idx]; // [R02]
            default: rd_val = 8'h00;
        endcase
    end

    // reply shifter: loaded after the code byte, shifted on later rises;
    // the host samples before our delayed shift lands, so hold time is safe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_ff <= 8'h00;
        end else if (!frame) begin
            tx_ff <= 8'h00;
        end else if (rise_bit && bitcnt_ff == FRM_CODE_END) begin
            tx_ff <= shreg_ff[7] ? rd_val : 8'h00; // [R02]
        end else if (rise_bit && bitcnt_ff > FRM_CODE_END) begin
            tx_ff <= {tx_ff[6:0], 1'b0};
        end
    end
    assign lnk.dev_data = tx_ff[7];

    // write decode
    always_comb begin
        tgt    = 2'b00;
        run_ok = 1'b0;
        wr_err = 1'b0;
        run_we = 2'b00;
        psc_we = 2'b00;
        tgt[0] = (sel_ff == SEL_CTL0) || (sel_ff == SEL_BOTH); // [R11]
        tgt[1] = (sel_ff == SEL_CTL1) || (sel_ff == SEL_BOTH); // [R11]
        run_ok = (byte_in[3:0] == 4'h0) &&
                 ((byte_in[7:6] == RUN_ON &&
                   (byte_in[5:4] == MRG_NOM || byte_in[5:4] == MRG_LOW ||
                    byte_in[5:4] == MRG_HIGH)) ||
                  ((byte_in[7:6] == RUN_IMM_OFF || byte_in[7:6] == RUN_SOFT_OFF) &&
                   byte_in[5:4] == MRG_NOM)); // [R13] [R16]
        if (wr_now) begin
            unique case (code_ff)
                CMD_SELECT: begin
                    wr_err = !(byte_in == SEL_CTL0 || byte_in == SEL_CTL1 ||
                               byte_in == SEL_BOTH); // [R22]
                end
                CMD_RUN: begin
                    wr_err = write_protect || !run_ok; // [R16] [R17]
                    run_we = wr_err ? 2'b00 : tgt;
                end
                CMD_PSC: begin
                    wr_err = write_protect; // [R17]
                    psc_we = wr_err ? 2'b00 : tgt;
                end
                CMD_STORE_DEF, CMD_REST_DEF, CMD_STORE_USR, CMD_REST_USR: begin
                    wr_err = 1'b0; // store contents live outside this block
                end
                default: wr_err = 1'b1;
            endcase
        end
    end

    // controller select: never write protected, bad values leave it alone
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel_ff <= SEL_RST; // [R12]
        end else if (wr_now && code_ff == CMD_SELECT && !wr_err) begin
            sel_ff <= byte_in; // [R11] [R12] [R22]
        end
    end

    // sticky command error; a new error in the clear cycle wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            err_ff <= 1'b0;
        end else begin
            err_ff <= wr_err | (err_ff & ~err_clear); // [R16] [R22]
        end
    end

    // per controller command registers and rail control
    for (genvar c = 0; c < 2; c++) begin : g_ctl
        logic       want_on;
        logic [2:0] src;
        logic       cmd_on;
        logic       imm;

        assign src    = act_psc_ff[c][4:2]; // [R18]
        assign cmd_on = (run_ff[c][7:6] == RUN_ON);
        // pin polarity bit is ignored: pin is always active high
        assign want_on = (src == SRC_PIN) ? en_lvl[c] :
                         (src == SRC_CMD) ? cmd_on :
                         (en_lvl[c] & cmd_on); // [R18] [R19]
        // immediate off from the command, or from config bit 0, skips the ramp
        assign imm = act_psc_ff[c][PSC_IMM_BIT] ||
                     (src != SRC_PIN && run_ff[c][7:6] == RUN_IMM_OFF); // [R14] [R20]

        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                run_ff[c] <= RUN_RST; // [R17]
                psc_ff[c] <= PSC_RST; // [R21]
            end else begin
                if (run_we[c]) begin
                    run_ff[c] <= byte_in; // [R17]
                end
                if (psc_we[c]) begin
                    psc_ff[c] <= byte_in;
                end
            end
        end

        // working config is frozen while the rail runs, picked up on next enable
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                act_psc_ff[c] <= PSC_RST; // [R21]
            end else if (!rail_ff[c]) begin
                act_psc_ff[c] <= psc_ff[c]; // [R03]
            end
        end

        // rail enable, margin select and ramp-down request
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                rail_ff[c]         <= 1'b0;
                soft_ff[c]         <= 1'b0;
                mrg_ff[2*c +: 2]   <= MRG_NOM;
            end else begin
                rail_ff[c]       <= want_on;
                mrg_ff[2*c +: 2] <= want_on ? run_ff[c][5:4] : MRG_NOM; // [R13]
                if (want_on) begin
                    soft_ff[c] <= 1'b0;
                end else if (rail_ff[c]) begin
                    soft_ff[c] <= !imm; // [R14] [R20]
                end
            end
        end
    end

    assign rail_on    = rail_ff;
    assign margin_sel = mrg_ff;
    assign soft_off   = soft_ff;
    assign cmd_error  = err_ff;
endmodule // prcd_device
`default_nettype wire

// ---- logic/prcd_host.sv ----
// host controller: avalon slave, link clock generator, frame engine, pacing
`timescale 1ns/1ps
`default_nettype none
module prcd_host #(
    parameter int HALF_CYC     = 12,
    parameter int READ_GAP_CYC = prcd_pkg::READ_GAP_CYC,
    parameter int CMD_GAP_CYC  = prcd_pkg::CMD_GAP_CYC,
    parameter int NV_GAP_CYC   = prcd_pkg::NV_GAP_CYC
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    prcd_if.host             lnk,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    import prcd_pkg::*;

    if (HALF_CYC < 4 || HALF_CYC > 256 || READ_GAP_CYC < 1 || CMD_GAP_CYC < 1 ||
        NV_GAP_CYC < 1) begin : g_bad_param
        $error("prcd_host: parameter out of range");
    end

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_GAP   = 2'b10
    } prcd_st_t;

    prcd_st_t    st_ff;
    logic [7:0]  div_ff;
    logic [31:0] gap_ff;
    logic [4:0]  bits_ff;
    logic [16:0] tx_ff;
    logic [7:0]  rx_ff;
    logic [7:0]  code_ff;
    logic        rd_ff;
    logic        lclk_ff;
    logic        frame_ff;
    logic        wait_ff;
    logic [31:0] rdata_ff;
    logic        dd_lvl;
    logic        busy;
    logic        start;
    logic        nv_cmd;

    prcd_sync #(.W(1)) u_dd_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (lnk.dev_data),
        .lvl    (dd_lvl),
        .rise   ()
    );

    assign busy   = (st_ff != ST_IDLE);
    // a command write waits for an idle engine
    assign start  = avs_write && !wait_ff && avs_address == HREG_CMD;
    assign nv_cmd = code_ff == CMD_STORE_DEF || code_ff == CMD_REST_DEF ||
                    code_ff == CMD_STORE_USR || code_ff == CMD_REST_USR;

    // avalon handshake: one wait cycle, commands also wait for idle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else if (!wait_ff) begin
            wait_ff <= 1'b1;
        end else if (avs_read) begin
            wait_ff  <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            if (avs_address == HREG_STATUS) begin
                rdata_ff[HST_BUSY_BIT] <= busy;
                rdata_ff[15:8]         <= rx_ff;
            end
        end else if (avs_write && (avs_address != HREG_CMD || !busy)) begin
            wait_ff <= 1'b0;
        end
    end

    // frame engine: clock low while data changes, device samples on rise
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_ff    <= ST_IDLE;
            div_ff   <= 8'h00;
            gap_ff   <= 32'h0000_0000;
            bits_ff  <= 5'd0;
            tx_ff    <= 17'h00000;
            rx_ff    <= 8'h00;
            code_ff  <= 8'h00;
            rd_ff    <= 1'b0;
            lclk_ff  <= 1'b0;
            frame_ff <= 1'b0;
        end else begin
            unique case (st_ff)
                ST_IDLE: begin
                    if (start) begin
                        tx_ff    <= {avs_writedata[HCMD_RD_BIT], avs_writedata[7:0],
                                     avs_writedata[15:8]};
                        code_ff  <= avs_writedata[7:0];
                        rd_ff    <= avs_writedata[HCMD_RD_BIT];
                        frame_ff <= 1'b1;
                        bits_ff  <= 5'd0;
                        div_ff   <= 8'h00;
                        st_ff    <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (div_ff == 8'(HALF_CYC - 1)) begin
                        div_ff  <= 8'h00;
                        lclk_ff <= !lclk_ff;
                        if (!lclk_ff) begin
                            if (bits_ff > FRM_CODE_END) begin
                                rx_ff <= {rx_ff[6:0], dd_lvl};
                            end
                        end else begin
                            tx_ff   <= {tx_ff[15:0], 1'b0};
                            bits_ff <= bits_ff + 5'd1;
                            if (bits_ff == FRM_BITS - 5'd1) begin
                                frame_ff <= 1'b0;
                                st_ff    <= ST_GAP;
                                // pacing depends on what was just sent
                                gap_ff <= nv_cmd ? 32'(NV_GAP_CYC) :
                                          rd_ff  ? 32'(READ_GAP_CYC) :
                                                   32'(CMD_GAP_CYC); // [R04] [R05] [R06]
                            end
                        end
                    end else begin
                        div_ff <= div_ff + 8'h01;
                    end
                end
                ST_GAP: begin
                    // no frame may start until the spacing has run out
                    if (gap_ff <= 32'h0000_0001) begin
                        st_ff <= ST_IDLE; // [R04] [R05] [R06]
                    end else begin
                        gap_ff <= gap_ff - 32'h0000_0001;
                    end
                end
                default: st_ff <= ST_IDLE;
            endcase
        end
    end

    // rail-off discipline while changing settings is left to software [R01]
    assign lnk.link_clk    = lclk_ff;
    assign lnk.link_frame  = frame_ff;
    assign lnk.host_data   = tx_ff[16];
    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
endmodule // prcd_host
`default_nettype wire

// ---- verif/prcd_asserts.sv ----
// link protocol checker
`timescale 1ns/1ps
`default_nettype none
module prcd_asserts
    import prcd_pkg::*;
#(
    parameter int READ_GAP_CYC = 20,
    parameter int CMD_GAP_CYC  = 40,
    parameter int NV_GAP_CYC   = 80
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic link_clk,
    input wire logic link_frame,
    input wire logic host_data,
    input wire logic dev_data
);
    logic        lclk_q_ff;
    logic        frm_q_ff;
    logic [8:0]  frm_cnt_ff;
    logic [4:0]  rise_cnt_ff;
    logic [16:0] sh_ff;
    logic [31:0] idle_cnt_ff;
    logic [31:0] gap_ff;
    logic        lrise;
    logic [7:0]  code;
    logic        nv;
    assign lrise = link_clk & ~lclk_q_ff;
    assign code  = sh_ff[15:8];
    assign nv    = code inside {CMD_STORE_DEF, CMD_REST_DEF, CMD_STORE_USR, CMD_REST_USR};
    // frame length, rises, shifted bits and idle time
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lclk_q_ff   <= 1'b0;
            frm_q_ff    <= 1'b0;
            frm_cnt_ff  <= 9'h0;
            rise_cnt_ff <= 5'h0;
            sh_ff       <= 17'h0;
            idle_cnt_ff <= 32'h0;
            gap_ff      <= 32'h0;
        end else begin
            lclk_q_ff   <= link_clk;
            frm_q_ff    <= link_frame;
            frm_cnt_ff  <= link_frame ? frm_cnt_ff + 9'h1 : 9'h0;
            rise_cnt_ff <= link_frame ? rise_cnt_ff + {4'h0, lrise} : 5'h0;
            idle_cnt_ff <= link_frame ? 32'h0 : idle_cnt_ff + 32'h1;
            if (lrise && link_frame) sh_ff <= {sh_ff[15:0], host_data};
            // gap owed by the kind of frame just sent
            if (frm_q_ff && !link_frame) begin
                gap_ff <= nv ? 32'(NV_GAP_CYC) : sh_ff[16] ? 32'(READ_GAP_CYC) : 32'(CMD_GAP_CYC);
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    idle_low_a: assert property (!link_frame |-> !link_clk)
        else $error("clock outside frame");
    reply_quiet_a: assert property ((!link_frame)[*8] |-> !dev_data)
        else $error("reply outside frame");
    half_high_a: assert property ($rose(link_clk) |-> ##11 link_clk ##1 !link_clk)
        else $error("clock high phase length");
    data_edge_a: assert property ($changed(host_data) |-> !link_clk)
        else $error("data moved while clock high");
    frame_len_a: assert property ($fell(link_frame) |-> frm_cnt_ff inside {[9'd406:9'd410]})
        else $error("frame length wrong");
    bit_count_a: assert property ($fell(link_frame) |-> rise_cnt_ff == 5'd17)
        else $error("bit count per frame");
    reply_stable_a: assert property ($rose(link_clk) |-> $stable(dev_data))
        else $error("reply moved at sampling");
    pace_gap_a: assert property ($rose(link_frame) |-> idle_cnt_ff >= gap_ff)
        else $error("pacing gap short");
endmodule // prcd_asserts
`default_nettype wire

// ---- verif/power_rail_command_decoder_tb_top.sv ----
// bench: host and device on one link, driven over avalon
`timescale 1ns/1ps
`default_nettype none
module power_rail_command_decoder_tb_top;
    import prcd_pkg::*;
    localparam logic [7:0] RUNV [6] = '{8'h80, 8'h90, 8'ha0, 8'h40, 8'h80, 8'h00};
    localparam logic [8:0] RUNE [6] = '{9'h003, 9'h017, 9'h02b, 9'h0c0, 9'h003, 9'h000};
    logic        clk;
    logic        resetn = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  en_pin = 2'b00;
    logic        write_protect = 1'b0;
    logic        err_clear = 1'b0;
    logic [1:0]  rail_on;
    logic [3:0]  margin_sel;
    logic [1:0]  soft_off;
    logic        cmd_error;
    logic [31:0] rd;
    int          n_errors;
    int          num_checks;
    prcd_if prcd_if_i ();
    prcd_host #(.READ_GAP_CYC(20), .CMD_GAP_CYC(40), .NV_GAP_CYC(80)) prcd_host_i (
        .clk(clk), .resetn(resetn), .lnk(prcd_if_i), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    prcd_device prcd_device_i (
        .clk(clk), .resetn(resetn), .lnk(prcd_if_i), .en_pin(en_pin),
        .write_protect(write_protect), .err_clear(err_clear), .rail_on(rail_on),
        .margin_sel(margin_sel), .soft_off(soft_off), .cmd_error(cmd_error));
    prcd_asserts #(.READ_GAP_CYC(20), .CMD_GAP_CYC(40), .NV_GAP_CYC(80)) prcd_asserts_i (
        .clk(clk), .resetn(resetn), .link_clk(prcd_if_i.link_clk),
        .link_frame(prcd_if_i.link_frame), .host_data(prcd_if_i.host_data),
        .dev_data(prcd_if_i.dev_data));
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one avalon access, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 5000);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
        if (k >= 5000) n_errors++;
        if (k >= 5000) close_out();
    endtask
    // one frame, then poll until idle
    task automatic cmd(input logic r, input logic [7:0] c, input logic [7:0] d);
        int k = 0;
        av(1'b1, HREG_CMD, {15'h0, r, d, c});
        do begin
            av(1'b0, HREG_STATUS, 32'h0);
            k++;
        end while (rd[HST_BUSY_BIT] !== 1'b0 && k < 2000);
        if (k >= 2000) n_errors++;
        if (k >= 2000) close_out();
    endtask
    task automatic rdc(input logic [7:0] c, input logic [7:0] e, input string nm);
        cmd(1'b1, c, 8'h00);
        chk(nm, rd, {16'h0, e, 8'h00});
    endtask
    task automatic outs(input logic [8:0] e, input string nm);
        chk(nm, {23'h0, cmd_error, soft_off, margin_sel, rail_on}, {23'h0, e});
    endtask
    task automatic clr();
        err_clear <= 1'b1;
        @(posedge clk);
        err_clear <= 1'b0;
        @(posedge clk);
        outs(9'h000, "error cleared");
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        outs(9'h000, "reset outs");
        rdc(CMD_SELECT, SEL_RST, "select reset");
        rdc(CMD_RUN, RUN_RST, "run reset");
        rdc(CMD_PSC, PSC_RST, "config reset");
        av(1'b1, 4'hc, 32'h0001_8001);
        av(1'b0, 4'h8, 32'h0);
        chk("unmapped read", rd, 32'h0);
        $display("test reset done");
        // default config: pin start, immediate off
        en_pin <= 2'b01;
        repeat (8) @(posedge clk);
        outs(9'h001, "pin start");
        rdc(CMD_RUN, 8'h80, "live on");
        en_pin <= 2'b00;
        repeat (8) @(posedge clk);
        outs(9'h000, "pin stop");
        cmd(1'b0, CMD_RUN, 8'h80);
        outs(9'h000, "pin only");
        $display("test pin done");
        // both controllers, command start, every run encoding
        cmd(1'b0, CMD_SELECT, SEL_BOTH);
        cmd(1'b0, CMD_PSC, 8'h18);
        for (int i = 0; i < 6; i++) begin
            cmd(1'b0, CMD_RUN, RUNV[i]);
            outs(RUNE[i], "run code");
        end
        rdc(CMD_RUN, 8'h00, "live off");
        $display("test run done");
        // refusals: bad encodings and protection
        cmd(1'b0, CMD_RUN, 8'h30);
        outs(9'h100, "bad run code");
        clr();
        cmd(1'b0, CMD_SELECT, 8'h02);
        outs(9'h100, "bad select");
        rdc(CMD_SELECT, SEL_BOTH, "select kept");
        clr();
        write_protect <= 1'b1;
        cmd(1'b0, CMD_SELECT, SEL_CTL1);
        rdc(CMD_SELECT, SEL_CTL1, "select free");
        cmd(1'b0, CMD_RUN, 8'h80);
        outs(9'h100, "protected run");
        clr();
        write_protect <= 1'b0;
        $display("test refusal done");
        // config written while on waits for the next enable
        cmd(1'b0, CMD_RUN, 8'h80);
        outs(9'h002, "ctl1 on");
        cmd(1'b0, CMD_PSC, 8'h19);
        cmd(1'b0, CMD_RUN, 8'h40);
        outs(9'h080, "old config");
        cmd(1'b0, CMD_RUN, 8'h80);
        cmd(1'b0, CMD_RUN, 8'h40);
        outs(9'h000, "new config");
        rdc(CMD_PSC, 8'h19, "config back");
        cmd(1'b0, CMD_STORE_USR, 8'h00);
        rdc(CMD_SELECT, SEL_CTL1, "after store");
        $display("test config done");
        close_out();
    end
endmodule // power_rail_command_decoder_tb_top
`default_nettype wire
